// ===== logic/mtd_decoder.sv
// Behaviour
// - Take 128-bit block, bit 127 marks mixed
// - Bit 124 selects between two decodes
// - Select clear: all colours are 5-6-5
// - Green LSBs of colours 3,1 from 126,125
// - Select clear: colour 2 green LSB is 33^126
// - Select clear: colour 0 green LSB is 1^125
// - Widen channels by replicating top bits
// - Select clear: two opaque four-entry tables
// - Texels 0-15 lower table, 16-31 upper
// - Lower table: ends plus rounded thirds
// - Upper table: colour 2, thirds, colour 3
// - Select set: colours 0,2 are 5-5-5
// - Select set: colours 1,3 5-6-5, no XOR
// - Select set: first, average, second, clear
// - Select set: index 3 is transparent black
// - Output texels as alpha, red, green, blue
`timescale 1ns/10ps

module mtd_decoder
  import mtd_pkg::*;
#(
  parameter int TEXELS = TEXEL_CNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [BLK_W-1:0] in_block,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_mixed,
  output mtd_argb_t [TEXEL_CNT-1:0] out_texels
);

  if (TEXELS != TEXEL_CNT) begin : g_chk
    $error("TEXELS must equal the texel count of one block");
  end

  function automatic logic [7:0] wide5(input logic [4:0] v);
    return {v, v[4:2]};
  endfunction : wide5

  function automatic logic [7:0] wide6(input logic [5:0] v);
    return {v, v[5:4]};
  endfunction : wide6

  // Rounded one-third blend, ten bits so 2*a+b+1 cannot wrap
  function automatic logic [7:0] third(input logic [7:0] a, input logic [7:0] b);
    logic [9:0] s;
    s = {1'b0, a, 1'b0} + {2'b00, b} + 10'h001;
    return 8'(s / 10'h003);
  endfunction : third

  function automatic logic [7:0] half(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8:1];
  endfunction : half

  function automatic mtd_argb_t opaque(input mtd_rgb_t c);
    return {ALPHA_OPAQUE, c.r, c.g, c.b};
  endfunction : opaque

  function automatic mtd_argb_t entry(
    input mtd_rgb_t x,
    input mtd_rgb_t y,
    input logic asel,
    input logic [1:0] sel
  );
    mtd_rgb_t m;
    mtd_argb_t e;
    m = '0;
    e = '0;
    if (!asel) begin
      case (sel)
        2'h0: e = opaque(x);
        2'h1: begin
          m.r = third(x.r, y.r);
          m.g = third(x.g, y.g);
          m.b = third(x.b, y.b);
          e = opaque(m);
        end
        2'h2: begin
          m.r = third(y.r, x.r);
          m.g = third(y.g, x.g);
          m.b = third(y.b, x.b);
          e = opaque(m);
        end
        default: e = opaque(y);
      endcase
    end else begin
      case (sel)
        2'h0: e = opaque(x);
        2'h1: begin
          m.r = half(x.r, y.r);
          m.g = half(x.g, y.g);
          m.b = half(x.b, y.b);
          e = opaque(m);
        end
        2'h2: e = opaque(y);
        default: e = {ALPHA_CLEAR, 24'h00_0000};
      endcase
    end
    return e;
  endfunction : entry

  mtd_regs_t q;
  mtd_regs_t d;
  mtd_rgb_t col [NUM_COL];
  logic [NUM_COL-1:0] glsb;
  logic asel;
  mtd_argb_t [TEXEL_CNT-1:0] tex_dec;

  assign asel = q.blk[ASEL_BIT];

  // Green LSBs; the XOR forms only matter for 5-6-5 colours 0 and 2
  always_comb begin
    glsb[3] = q.blk[C3_GLSB_BIT];
    glsb[1] = q.blk[C1_GLSB_BIT];
    glsb[2] = q.blk[C2_XOR_BIT] ^ q.blk[C3_GLSB_BIT];
    glsb[0] = q.blk[C0_XOR_BIT] ^ q.blk[C1_GLSB_BIT];
  end

  always_comb begin
    logic [4:0] g5;
    g5 = '0;
    for (int i = 0; i < NUM_COL; i++) begin
      g5 = q.blk[COL_BASE + i * COL_STRIDE + GRN_OFS +: CH_W];
      col[i].r = wide5(q.blk[COL_BASE + i * COL_STRIDE + RED_OFS +: CH_W]);
      col[i].b = wide5(q.blk[COL_BASE + i * COL_STRIDE + BLU_OFS +: CH_W]);
      if (!asel || i[0]) begin
        col[i].g = wide6({g5, glsb[i]});
      end else begin
        col[i].g = wide5(g5);
      end
    end
  end

  always_comb begin
    for (int n = 0; n < TEXEL_CNT; n++) begin
      if (n < TEXEL_HALF) begin
        tex_dec[n] = entry(col[0], col[1], asel, q.blk[SEL_W * n +: SEL_W]);
      end else begin
        tex_dec[n] = entry(col[2], col[3], asel, q.blk[SEL_W * n +: SEL_W]);
      end
    end
  end

  // One block in flight keeps the 1024-bit result stable while held
  always_comb begin
    d = q;
    case (q.st)
      MTD_IDLE: begin
        if (in_valid) begin
          d.blk = in_block;
          d.rdy = 1'b0;
          d.st = MTD_DECODE;
        end
      end
      MTD_DECODE: begin
        d.tex = tex_dec;
        d.mixed = q.blk[MODE_BIT];
        d.vld = 1'b1;
        d.st = MTD_HOLD;
      end
      MTD_HOLD: begin
        if (out_ready) begin
          d.vld = 1'b0;
          d.rdy = 1'b1;
          d.st = MTD_IDLE;
        end
      end
      default: d = MTD_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= MTD_RST;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = q.vld;
  assign out_mixed = q.mixed;
  assign out_texels = q.tex;

  logic all_opaque;
  always_comb begin
    all_opaque = 1'b1;
    for (int n = 0; n < TEXEL_CNT; n++) begin
      if (q.tex[n].a != ALPHA_OPAQUE) begin
        all_opaque = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_latency;
    in_valid && in_ready |=> !in_ready ##1 out_valid && out_mixed == $past(in_block[MODE_BIT], 2);
  endproperty
  a_latency: assert property (p_latency) else $error("decode not presented two cycles after accept");

  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_texels);
  endproperty
  a_hold: assert property (p_hold) else $error("texels dropped or changed while stalled");

  property p_release;
    out_valid && out_ready |=> !out_valid && in_ready;
  endproperty
  a_release: assert property (p_release) else $error("no return to ready after hand-off");

  property p_opaque;
    out_valid && !asel |-> all_opaque;
  endproperty
  a_opaque: assert property (p_opaque) else $error("select clear gave non-opaque texel");

  property p_clear;
    out_valid && asel && q.blk[1:0] == SEL_LAST |-> out_texels[0] == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("index 3 not transparent black");

  property p_c0red;
    out_valid && q.blk[1:0] == 2'h0 |-> out_texels[0].r == {q.blk[78:74], q.blk[78:76]};
  endproperty
  a_c0red: assert property (p_c0red) else $error("colour 0 red widening wrong");

  property p_c3grn;
    out_valid && q.blk[63:62] == SEL_LAST && !asel
      |-> out_texels[31].g[7:2] == {q.blk[118:114], q.blk[126]};
  endproperty
  a_c3grn: assert property (p_c3grn) else $error("colour 3 green LSB wrong");

  property p_c2xor;
    out_valid && q.blk[33:32] == 2'h0 && !asel
      |-> out_texels[16].g[2] == (q.blk[33] ^ q.blk[126]);
  endproperty
  a_c2xor: assert property (p_c2xor) else $error("colour 2 green XOR wrong");

  property p_c0mid;
    out_valid && asel && q.blk[1:0] == SEL_MID
      |-> out_texels[0].b == 8'(({1'b0, col[0].b} + {1'b0, col[1].b}) >> 1);
  endproperty
  a_c0mid: assert property (p_c0mid) else $error("midpoint entry wrong");

  property p_busy;
    out_valid |-> !in_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready raised while texels still shown");

  property p_c1grn;
    out_valid && q.blk[1:0] == SEL_LAST && !asel
      |-> out_texels[0].g[7:2] == {q.blk[88:84], q.blk[125]};
  endproperty
  a_c1grn: assert property (p_c1grn) else $error("colour 1 green LSB wrong");

  // Texel 1 shows colour 0 whatever bit 1 holds, so both XOR inputs vary
  property p_c0xor;
    out_valid && q.blk[3:2] == 2'h0 && !asel
      |-> out_texels[1].g[2] == (q.blk[1] ^ q.blk[125]);
  endproperty
  a_c0xor: assert property (p_c0xor) else $error("colour 0 green XOR wrong");

  property p_c2xor1;
    out_valid && q.blk[35:34] == 2'h0 && !asel
      |-> out_texels[17].g[2] == (q.blk[33] ^ q.blk[126]);
  endproperty
  a_c2xor1: assert property (p_c2xor1) else $error("texel 17 green XOR wrong");

  property p_c3red;
    out_valid && q.blk[63:62] == SEL_LAST && !asel
      |-> out_texels[31].r == {q.blk[123:119], q.blk[123:121]};
  endproperty
  a_c3red: assert property (p_c3red) else $error("colour 3 red widening wrong");

  property p_c2red;
    out_valid && q.blk[33:32] == 2'h0
      |-> out_texels[16].r == {q.blk[108:104], q.blk[108:106]};
  endproperty
  a_c2red: assert property (p_c2red) else $error("texel 16 not from colour 2");

  property p_c0g555;
    out_valid && asel && q.blk[1:0] == 2'h0
      |-> out_texels[0].g == {q.blk[73:69], q.blk[73:71]};
  endproperty
  a_c0g555: assert property (p_c0g555) else $error("colour 0 five-bit green wrong");

  property p_c1g565;
    out_valid && asel && q.blk[1:0] == 2'h2
      |-> out_texels[0].g == {q.blk[88:84], q.blk[125], q.blk[88:87]};
  endproperty
  a_c1g565: assert property (p_c1g565) else $error("colour 1 six-bit green wrong");

  property p_setopq;
    out_valid && asel && q.blk[1:0] != SEL_LAST |-> out_texels[0].a == ALPHA_OPAQUE;
  endproperty
  a_setopq: assert property (p_setopq) else $error("select set gave non-opaque entry");

endmodule : mtd_decoder

// ===== logic/mtd_pkg.sv
package mtd_pkg;

  localparam int BLK_W = 128;
  localparam int MODE_BIT = 127;
  localparam int C3_GLSB_BIT = 126;
  localparam int C1_GLSB_BIT = 125;
  localparam int ASEL_BIT = 124;
  localparam int C2_XOR_BIT = 33;
  localparam int C0_XOR_BIT = 1;

  // Colour n channels start at COL_BASE + n * COL_STRIDE
  localparam int COL_BASE = 64;
  localparam int COL_STRIDE = 15;
  localparam int CH_W = 5;
  localparam int RED_OFS = 10;
  localparam int GRN_OFS = 5;
  localparam int BLU_OFS = 0;
  localparam int NUM_COL = 4;

  localparam int SEL_W = 2;
  localparam int TEXEL_CNT = 32;
  localparam int TEXEL_HALF = 16;

  localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;
  localparam logic [7:0] ALPHA_CLEAR = 8'h00;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_LAST = 2'h3;

  typedef enum logic [1:0] {
    MTD_IDLE,
    MTD_DECODE,
    MTD_HOLD
  } mtd_state_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } mtd_rgb_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } mtd_argb_t;

  typedef struct packed {
    mtd_state_t st;
    logic rdy;
    logic vld;
    logic mixed;
    logic [BLK_W-1:0] blk;
    mtd_argb_t [TEXEL_CNT-1:0] tex;
  } mtd_regs_t;

  localparam mtd_regs_t MTD_RST = '{
    st: MTD_IDLE,
    rdy: 1'b1,
    vld: 1'b0,
    mixed: 1'b0,
    blk: '0,
    tex: '0
  };

endpackage : mtd_pkg

// ===== verification/mtd_decoder_tb.sv
`timescale 1ns/10ps
module mtd_decoder_tb;
  import mtd_pkg::*;
  typedef mtd_argb_t [TEXEL_CNT-1:0] mtd_tex_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic in_valid, in_ready, out_valid, out_ready, out_mixed;
  logic [BLK_W-1:0] in_block;
  logic [BLK_W-1:0] blk = '0;
  mtd_tex_t out_texels, ex;
  int n_fail = 0;
  int tests_run = 0;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end
  always #4 clk = ~clk;
  mtd_sampler u_far (.clk(clk), .rst(rst), .go(go), .stall(stall), .blk(blk),
    .in_ready(in_ready), .in_valid(in_valid), .in_block(in_block), .out_ready(out_ready));
  mtd_decoder #(.TEXELS(TEXEL_CNT)) DUT (.clk(clk), .rst(rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_block(in_block), .out_valid(out_valid),
    .out_ready(out_ready), .out_mixed(out_mixed), .out_texels(out_texels));
  function automatic logic [7:0] w5(logic [4:0] c);
    return {c, c[4:2]};
  endfunction : w5
  function automatic logic [7:0] w6(logic [5:0] c);
    return {c, c[5:4]};
  endfunction : w6
  function automatic logic [7:0] pk(logic [7:0] a, logic [7:0] b, logic s, logic [1:0] i);
    logic [9:0] x, y;
    x = {2'b00, a};
    y = {2'b00, b};
    if (s) return (i == 0) ? a : (i == 1) ? 8'((x + y) >> 1) : (i == 2) ? b : 8'h00;
    return (i == 0) ? a : (i == 1) ? 8'((2*x + y + 1) / 3) : (i == 2) ? 8'((x + 2*y + 1) / 3) : b;
  endfunction : pk
  function automatic mtd_rgb_t col(logic [BLK_W-1:0] k, int n);
    int b;
    logic l;
    mtd_rgb_t c;
    b = COL_BASE + n * COL_STRIDE;
    l = (n == 3) ? k[126] : (n == 1) ? k[125] : (n == 2) ? k[33] ^ k[126] : k[1] ^ k[125];
    c.r = w5(k[b+RED_OFS +: CH_W]);
    c.b = w5(k[b+BLU_OFS +: CH_W]);
    c.g = (k[124] && n % 2 == 0) ? w5(k[b+GRN_OFS +: CH_W]) : w6({k[b+GRN_OFS +: CH_W], l});
    return c;
  endfunction : col
  function automatic mtd_tex_t model(logic [BLK_W-1:0] k);
    mtd_rgb_t a, b;
    logic [1:0] i;
    mtd_tex_t r;
    for (int t = 0; t < TEXEL_CNT; t++) begin
      a = col(k, t < 16 ? 0 : 2);
      b = col(k, t < 16 ? 1 : 3);
      i = k[2*t +: 2];
      r[t] = {(k[124] && i == 3) ? 8'h00 : 8'hFF, pk(a.r, b.r, k[124], i),
        pk(a.g, b.g, k[124], i), pk(a.b, b.b, k[124], i)};
    end
    return r;
  endfunction : model
  task automatic xfer(input logic [BLK_W-1:0] k, input int hold);
    ex = model(k);
    blk = k;
    stall = hold > 0;
    go = 1'b1;
    @(posedge clk iff (in_valid && in_ready));
    go = 1'b0;
    #2 `CHK("in_ready", 1'b0, in_ready)
    `CHK("out_valid", 1'b0, out_valid)
    @(posedge clk);
    #2 `CHK("out_valid", 1'b1, out_valid)
    `CHK("out_mixed", k[127], out_mixed)
    for (int t = 0; t < TEXEL_CNT; t++) `CHK("texel", ex[t], out_texels[t])
    repeat (hold) @(posedge clk);
    #2 `CHK("held texels", ex, out_texels)
    stall = 1'b0;
    @(posedge clk iff (out_valid && out_ready));
    #2 `CHK("out_valid", 1'b0, out_valid)
    `CHK("in_ready", 1'b1, in_ready)
  endtask : xfer
  task automatic t_reset();
    `CHK("in_ready", 1'b1, in_ready)
    `CHK("out_valid", 1'b0, out_valid)
    `CHK("out_mixed", 1'b0, out_mixed)
    `CHK("texels", '0, out_texels)
    $display("test reset done");
  endtask : t_reset
  task automatic t_opaque();
    xfer(128'hE7A5_3C96_0F1E_D2B4_E4E4_1B1B_E4E4_1B1E, 0);
    xfer(128'h6BCD_1234_FEDC_5678_AAAA_5555_FFFF_0000, 0);
    xfer(128'hE7A5_3C96_0F1E_D2B4_E4E4_1B19_E4E4_1B1C, 0);
    xfer(128'hC3C3_A5A5_5A5A_3C3C_0000_0003_0000_0003, 0);
    xfer(128'hCE2D_B1C7_9A3F_0E6B_C000_0000_7FFF_8000, 0);
    $display("test opaque done");
  endtask : t_opaque
  task automatic t_alpha();
    xfer(128'h9123_4567_89AB_CDEF_1B1B_E4E4_0123_4567, 3);
    xfer(128'hDA5F_0C33_7E81_46B9_39C6_E41B_9C63_D28E, 0);
    xfer(128'hB5E1_4C2D_7A93_E6F0_3300_C0FF_0F0F_0F04, 2);
    $display("test alpha done");
  endtask : t_alpha
  task automatic t_midreset();
    blk = 128'hF0F0_5A5A_C3C3_9696_E4E4_E4E4_1B1B_1B1B;
    stall = 1'b1;
    go = 1'b1;
    @(posedge clk iff (in_valid && in_ready));
    go = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    stall = 1'b0;
    t_reset();
    xfer(128'hF0F0_5A5A_C3C3_9696_E4E4_E4E4_1B1B_1B1B, 0);
    $display("test midreset done");
  endtask : t_midreset
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_opaque();
    t_alpha();
    t_midreset();
    conclude();
  end
  // About 2500 cycles, far beyond the fifty-odd the tests need
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule : mtd_decoder_tb

// ===== verification/mtd_sampler.sv
`timescale 1ns/10ps
module mtd_sampler
  import mtd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic stall,
  input wire logic [BLK_W-1:0] blk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [BLK_W-1:0] in_block,
  output logic out_ready
);
  logic tk;
  logic rs;
  logic gq;
  logic sq;
  initial begin
    in_valid = 1'b0;
    in_block = '0;
    out_ready = 1'b0;
  end
  // Controls are taken at the edge and applied 1 ns later, so bench writes never race
  // Idle data keeps toggling so a stale block cannot pass for a fresh one
  always @(posedge clk) begin
    tk = in_valid && in_ready;
    rs = rst;
    gq = go;
    sq = stall;
    #1;
    if (rs || tk) begin
      in_valid = 1'b0;
    end
    if (gq && !in_valid && !tk && !rs) begin
      in_valid = 1'b1;
      in_block = blk;
    end else if (!in_valid) begin
      in_block = ~in_block;
    end
    out_ready = !sq;
  end
endmodule : mtd_sampler
